// ===== hdl/backlight_sequencer.v
/*
 * backlight timeout and fade sequencer with its register file.
 * assumes a host on the i2c pins and a standby pin from outside.
 */
//
// Contract
// (R1) off timeout: 7-bit code, zero disables, N gives N seconds.
// (R2) off expiry turns backlight off; off count follows an enabled dim count.
// (R3) dim timeout: 7-bit code, zero disables, N gives N seconds.
// (R4) dim expiry moves backlight to the active level's dim current.
// (R5) dim count starts only once maximum current is reached.
// (R6) fade-out rate in bits 7:4; zero means change within 100 ms.
// (R7) nonzero fade-out rate ramps current down to dim or off target.
// (R8) fade-out codes pick 0.3 to 5.5 s full-scale durations.
// (R9) fade-in rate in bits 3:0; zero means change within 100 ms.
// (R10) nonzero fade-in rate ramps current up to the level maximum.
// (R11) fade-in codes use the same duration table as fade out.
// (R12) durations are full-scale; shorter swings take proportionally less time.
// (R13) daylight maximum code is the target while daylight is active, undimmed.
// (R14) linear law: about 0.236 mA per code, 30 mA at 0x7F.
// (R15) square law: current follows code squared, 30 mA at 0x7F.
// (R16) cubic laws use square mapping but vary time per step.
// (R17) 2-bit law field: linear, square, and two cubic step profiles.
// (R18) 2-bit level field: daylight, office, dark, or forced zero.
// (R19) sequence runs only with enable set and standby not asserted.
// (R20) software dim flag also applies the active level's dim current.
// (R21) one-second and fade-step ticks derived from the internal clock.
// (R22) reserved bit 7 of timeout and current registers reads zero.
// (R23) timeout rewrite restarts the count; fades never jump to target.
`timescale 1ns/1ps
`include "backlight_consts.vh"
`default_nettype none
module backlight_sequencer #(
  parameter [6:0] I2C_ADDR      = `I2C_ADDR_RESET,
  parameter       CYCLES_PER_MS = `CLK_FREQ_HZ / `MS_PER_SECOND
) (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST_N,
  // i2c pins
  input  wire        SCL,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  // standby pin
  input  wire        STANDBY_PIN_N,
  // sink drive
  output reg  [6:0]  SINK_CODE,
  output reg         SQUARE_LAW,
  output reg  [14:0] SINK_CURRENT_UA,
  output reg         BACKLIGHT_ON
);
  localparam S_IDLE = 3'd0, S_RISE = 3'd1, S_MAX = 3'd2;
  localparam S_DIM  = 3'd3, S_OFF  = 3'd4;
  localparam [31:0] SECOND_CYCLES = CYCLES_PER_MS * `MS_PER_SECOND;

  // ****************************************************
  // register file
  // ****************************************************
  wire       wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [7:0] rd_addr;
  reg  [7:0] rd_data;
  reg        enable;
  reg        dim_flag;
  reg  [1:0] law;
  reg  [1:0] level_sel;
  reg  [6:0] off_timeout_code;
  reg  [6:0] dim_timeout_code;
  reg  [3:0] fade_out_rate;
  reg  [3:0] fade_in_rate;
  reg  [6:0] level_code [0:5];
  reg        reload;
  reg  [2:0] state;
  reg  [1:0] stby_s;
  reg        dim_prev;
  reg  [6:0] secs;
  reg        sec_restart;
  wire       sec_tick;
  wire       step_tick;
  wire [2:0] wr_idx = wr_addr[2:0] - 3'd1;
  integer    i;

  i2c_reg_port #(
    .DEV_ADDR (I2C_ADDR)
  ) u_port (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .scl_pin (SCL),
    .sda_pin (SDA_IN),
    .sda_out (SDA_OUT),
    .sda_oe  (SDA_OE),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable           <= 1'b0;
      dim_flag         <= 1'b0;
      law              <= `LAW_LINEAR;
      level_sel        <= 2'h0;
      off_timeout_code <= `CODE_RESET;
      dim_timeout_code <= `CODE_RESET;
      fade_out_rate    <= 4'h0;
      fade_in_rate     <= 4'h0;
      reload           <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
        level_code[i] <= `CODE_RESET;
    end else begin
      reload <= 1'b0;
      if (wr_en) begin
        case (wr_addr)
          `ADDR_MODE_CONTROL: begin
            enable   <= wr_data[`MODE_ENABLE_BIT];
            dim_flag <= wr_data[`MODE_DIM_BIT];
          end
          `ADDR_CONFIG: begin
            law       <= wr_data[`CFG_LAW_LSB +: 2];
            level_sel <= wr_data[`CFG_LEVEL_LSB +: 2];
          end
          // (R22) bit 7 dropped
          // (R1) off code held
          `ADDR_OFF_TIMEOUT: begin
            off_timeout_code <= wr_data[6:0];
            reload           <= 1'b1;
          end
          // (R3) dim code held
          `ADDR_DIM_TIMEOUT: begin
            dim_timeout_code <= wr_data[6:0];
            reload           <= 1'b1;
          end
          // (R6) (R9) rate fields
          `ADDR_FADE_RATES: begin
            fade_out_rate <= wr_data[`FADE_OUT_LSB +: 4];
            fade_in_rate  <= wr_data[`FADE_IN_LSB +: 4];
          end
          default: begin
            // (R13) level current codes
            if (wr_addr >= `ADDR_LEVEL_FIRST && wr_addr <= `ADDR_LEVEL_LAST)
              level_code[wr_idx] <= wr_data[6:0];
          end
        endcase
      end
    end
  end

  // unmapped offsets read as zero
  always @* begin
    rd_data = `REG_RESET;
    case (rd_addr)
      `ADDR_MODE_CONTROL: begin
        rd_data[`MODE_ENABLE_BIT] = enable;
        rd_data[`MODE_DIM_BIT]    = dim_flag;
      end
      `ADDR_CONFIG: begin
        rd_data[`CFG_LAW_LSB +: 2]   = law;
        rd_data[`CFG_LEVEL_LSB +: 2] = level_sel;
      end
      `ADDR_OFF_TIMEOUT:  rd_data = {1'b0, off_timeout_code};
      `ADDR_DIM_TIMEOUT:  rd_data = {1'b0, dim_timeout_code};
      `ADDR_FADE_RATES:   rd_data = {fade_out_rate, fade_in_rate};
      `ADDR_STATUS_CODE:  rd_data = {1'b0, SINK_CODE};
      `ADDR_STATUS_STATE: rd_data = {5'h00, state};
      default: begin
        if (rd_addr >= `ADDR_LEVEL_FIRST && rd_addr <= `ADDR_LEVEL_LAST)
          rd_data = {1'b0, level_code[rd_addr[2:0] - 3'd1]};
      end
    endcase
  end

  // ****************************************************
  // targets and fade timing
  // ****************************************************
  // (R18) level picks code pair
  wire [2:0] max_idx  = {level_sel[1:0], 1'b0};
  wire [2:0] dim_idx  = {level_sel[1:0], 1'b1};
  wire       lvl_off  = (level_sel == `LEVEL_OFF);
  wire [6:0] max_code = lvl_off ? 7'h00 : level_code[max_idx];
  wire [6:0] dim_code = lvl_off ? 7'h00 : level_code[dim_idx];
  wire       standby  = ~stby_s[1];
  wire       run      = enable & ~standby;
  reg  [6:0] target;

  // (R4) (R20) (R7) target per state
  always @* begin
    case (state)
      S_RISE:  target = dim_flag ? dim_code : max_code;
      S_MAX:   target = max_code;
      S_DIM:   target = dim_code;
      default: target = 7'h00;
    endcase
  end

  // (R8) (R11) shared duration table
  function [12:0] fade_ms;
    input [3:0] rate;
    begin
      case (rate)
        4'h0:    fade_ms = `FADE_MS_0;
        4'h1:    fade_ms = `FADE_MS_1;
        4'h2:    fade_ms = `FADE_MS_2;
        4'h3:    fade_ms = `FADE_MS_3;
        4'h4:    fade_ms = `FADE_MS_4;
        4'h5:    fade_ms = `FADE_MS_5;
        4'h6:    fade_ms = `FADE_MS_6;
        4'h7:    fade_ms = `FADE_MS_7;
        4'h8:    fade_ms = `FADE_MS_8;
        4'h9:    fade_ms = `FADE_MS_9;
        4'hA:    fade_ms = `FADE_MS_10;
        4'hB:    fade_ms = `FADE_MS_11;
        4'hC:    fade_ms = `FADE_MS_12;
        4'hD:    fade_ms = `FADE_MS_13;
        4'hE:    fade_ms = `FADE_MS_14;
        default: fade_ms = `FADE_MS_15;
      endcase
    end
  endfunction

  // (R12) per-code period; full scale is 127 steps
  wire        going_up  = target > SINK_CODE;
  wire [3:0]  rate      = going_up ? fade_in_rate : fade_out_rate;
  wire [31:0] full_cyc  = {19'h0, fade_ms(rate)} * CYCLES_PER_MS;
  wire [31:0] base_step = full_cyc / `FULL_SCALE_CODE;
  // (R16) (R17) cubic laws stretch steps, low end or high end
  wire [3:0]  weight    = (law == `LAW_CUBIC_10) ? 4'd8 + {1'b0, ~SINK_CODE[6:4]} :
                          (law == `LAW_CUBIC_11) ? 4'd8 + {1'b0, SINK_CODE[6:4]} :
                          4'd8;
  wire [35:0] scaled    = base_step * weight;
  wire [31:0] step_raw  = scaled[34:3];
  wire [31:0] step_per  = (step_raw == 32'h0) ? 32'h1 : step_raw;
  wire        at_target = (SINK_CODE == target);

  // (R21) one-second tick
  fade_step_timer #(
    .W (32)
  ) u_sec (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .restart (sec_restart),
    .period  (SECOND_CYCLES),
    .tick    (sec_tick)
  );

  // (R21) fade step tick, idle while at target
  fade_step_timer #(
    .W (32)
  ) u_step (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .restart (at_target),
    .period  (step_per),
    .tick    (step_tick)
  );

  // ****************************************************
  // sequencer
  // ****************************************************
  wire expire = sec_tick && (secs == 7'd1);
  // counting at maximum: dim first if enabled, else off
  wire [6:0] max_load = (dim_timeout_code != 7'h00) ? dim_timeout_code
                                                    : off_timeout_code;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stby_s      <= 2'h0;
      state       <= S_IDLE;
      dim_prev    <= 1'b0;
      secs        <= 7'h00;
      sec_restart <= 1'b0;
    end else begin
      stby_s      <= {stby_s[0], STANDBY_PIN_N};
      dim_prev    <= dim_flag;
      sec_restart <= 1'b0;
      if (sec_tick && secs != 7'h00)
        secs <= secs - 7'd1;
      // (R19) enable and standby gate
      if (!run) begin
        state <= S_IDLE;
        secs  <= 7'h00;
      end else begin
        case (state)
          S_IDLE: state <= S_RISE;
          // (R5) dim count waits for maximum
          S_RISE: if (dim_flag) begin
            state       <= S_DIM;
            secs        <= off_timeout_code;
            sec_restart <= 1'b1;
          end else if (at_target) begin
            state       <= S_MAX;
            secs        <= max_load;
            sec_restart <= 1'b1;
          end
          S_MAX: if (dim_flag || (expire && dim_timeout_code != 7'h00)) begin
            // (R2) off count after dim
            state       <= S_DIM;
            secs        <= off_timeout_code;
            sec_restart <= 1'b1;
          end else if (expire) begin
            state <= S_OFF;
          end else if (reload) begin
            // (R23) restart from new code
            secs        <= max_load;
            sec_restart <= 1'b1;
          end
          S_DIM: if (dim_prev && !dim_flag) begin
            state <= S_RISE;
            secs  <= 7'h00;
          end else if (expire) begin
            // (R2) off on expiry
            state <= S_OFF;
          end else if (reload) begin
            secs        <= off_timeout_code;
            sec_restart <= 1'b1;
          end
          S_OFF:   state <= S_OFF;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************************
  // current code and sink outputs
  // ****************************************************
  wire [31:0] c32   = {25'h0, SINK_CODE};
  // (R14) linear, rounded to nearest uA
  wire [31:0] lin   = (c32 * `FULL_SCALE_UA + 32'd63) / `FULL_SCALE_CODE;
  // (R15) square law
  wire [31:0] sq    = (c32 * c32 * `FULL_SCALE_UA + 32'd8064) / 32'd16129;
  wire        sqlaw = (law != `LAW_LINEAR);

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SINK_CODE       <= `CODE_RESET;
      SQUARE_LAW      <= 1'b0;
      SINK_CURRENT_UA <= 15'h0000;
      BACKLIGHT_ON    <= 1'b0;
    end else begin
      SQUARE_LAW      <= sqlaw;
      SINK_CURRENT_UA <= sqlaw ? sq[14:0] : lin[14:0];
      BACKLIGHT_ON    <= (SINK_CODE != 7'h00);
      // standby drops the sinks at once to save supply current
      if (standby) begin
        SINK_CODE <= 7'h00;
      // (R10) (R23) one code per step, never a jump
      end else if (step_tick && !at_target) begin
        if (going_up)
          SINK_CODE <= SINK_CODE + 7'd1;
        else
          SINK_CODE <= SINK_CODE - 7'd1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== common/backlight_consts.vh
/*
 * constants for the backlight sequencer: register offsets, field
 * positions, reset values and timing figures.
 * assumes inclusion by bare name from the design files.
 */
`ifndef BACKLIGHT_CONSTS_VH
`define BACKLIGHT_CONSTS_VH

// ****************************************************
// register offsets
// ****************************************************
`define ADDR_MODE_CONTROL 8'h01
`define ADDR_CONFIG       8'h04
`define ADDR_OFF_TIMEOUT  8'h06
`define ADDR_DIM_TIMEOUT  8'h07
`define ADDR_FADE_RATES   8'h08
`define ADDR_LEVEL_FIRST  8'h09
`define ADDR_LEVEL_LAST   8'h0E
`define ADDR_STATUS_CODE  8'h20
`define ADDR_STATUS_STATE 8'h21

// ****************************************************
// fields and reset values
// ****************************************************
`define MODE_ENABLE_BIT 0
`define MODE_DIM_BIT    4
`define CFG_LAW_LSB     1
`define CFG_LEVEL_LSB   3
`define FADE_IN_LSB     0
`define FADE_OUT_LSB    4
`define REG_RESET       8'h00
`define CODE_RESET      7'h00
`define LEVEL_OFF       2'h3
`define LAW_LINEAR      2'h0
`define LAW_CUBIC_10    2'h2
`define LAW_CUBIC_11    2'h3
// bus address value is arbitrary
`define I2C_ADDR_RESET  7'h3C

// ****************************************************
// timing and scale
// ****************************************************
`define CLK_FREQ_HZ     50000000
`define MS_PER_SECOND   1000
`define FULL_SCALE_UA   30000
`define FULL_SCALE_CODE 127
`define FADE_MS_0  13'd100
`define FADE_MS_1  13'd300
`define FADE_MS_2  13'd600
`define FADE_MS_3  13'd900
`define FADE_MS_4  13'd1200
`define FADE_MS_5  13'd1500
`define FADE_MS_6  13'd1800
`define FADE_MS_7  13'd2100
`define FADE_MS_8  13'd2400
`define FADE_MS_9  13'd2700
`define FADE_MS_10 13'd3000
`define FADE_MS_11 13'd3500
`define FADE_MS_12 13'd4000
`define FADE_MS_13 13'd4500
`define FADE_MS_14 13'd5000
`define FADE_MS_15 13'd5500

`endif

// ===== hdl/fade_step_timer.v
/*
 * periodic tick generator with a run-time period and a restart.
 * assumes period is at least one and is stable between ticks.
 */
`timescale 1ns/1ps
`default_nettype none
module fade_step_timer #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // control
  input  wire         restart,
  input  wire [W-1:0] period,
  // tick out
  output reg          tick
);
  reg [W-1:0] count;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (restart) begin
        count <= {W{1'b0}};
      end else if (count >= period - {{(W-1){1'b0}}, 1'b1}) begin
        count <= {W{1'b0}};
        tick  <= 1'b1;
      end else begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/i2c_reg_port.v
/*
 * i2c-compatible register port: address byte, pointer byte, then data
 * bytes with auto-increment; reads return data from the pointer.
 * assumes scl and sda come straight from pins, sda open drain.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_port #(
  parameter [6:0] DEV_ADDR = 7'h3C
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // pins
  input  wire       scl_pin,
  input  wire       sda_pin,
  output reg        sda_out,
  output reg        sda_oe,
  // register access
  output reg        wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data
);
  localparam IDLE = 3'd0, ADDR = 3'd1, ACK_A = 3'd2, WDATA = 3'd3;
  localparam ACK_W = 3'd4, RDATA = 3'd5, ACK_R = 3'd6;

  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] shift;
  reg [7:0] ptr;
  reg       rw;
  reg       first;
  reg       nack;

  // ****************************************************
  // pin synchronisers and bus events
  // ****************************************************
  wire rise  = scl_s[1] & ~scl_s[2];
  wire fall  = ~scl_s[1] & scl_s[2];
  wire start = scl_s[1] & sda_s[2] & ~sda_s[1];
  wire stop  = scl_s[1] & ~sda_s[2] & sda_s[1];
  assign rd_addr = ptr;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_pin};
      sda_s <= {sda_s[1:0], sda_pin};
    end
  end

  // ****************************************************
  // protocol engine
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= IDLE;
      cnt     <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      first   <= 1'b0;
      nack    <= 1'b1;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start) begin
        state  <= ADDR;
        cnt    <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        state  <= IDLE;
        sda_oe <= 1'b0;
      end else if (rise) begin
        if (state == ADDR || state == WDATA) begin
          shift <= {shift[6:0], sda_s[1]};
          cnt   <= cnt + 4'h1;
        end
        if (state == ACK_R)
          nack <= sda_s[1];
      end else if (fall) begin
        case (state)
          ADDR: if (cnt == 4'h8) begin
            if (shift[7:1] == DEV_ADDR) begin
              state  <= ACK_A;
              sda_oe <= 1'b1;
              rw     <= shift[0];
              first  <= 1'b1;
            end else begin
              state <= IDLE;
            end
          end
          ACK_A: begin
            cnt <= 4'h0;
            if (rw) begin
              state  <= RDATA;
              shift  <= rd_data;
              sda_oe <= ~rd_data[7];
              cnt    <= 4'h1;
            end else begin
              state  <= WDATA;
              sda_oe <= 1'b0;
            end
          end
          WDATA: if (cnt == 4'h8) begin
            state  <= ACK_W;
            sda_oe <= 1'b1;
            first  <= 1'b0;
            if (first) begin
              ptr <= shift;
            end else begin
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shift;
              ptr     <= ptr + 8'h01;
            end
          end
          ACK_W: begin
            state  <= WDATA;
            sda_oe <= 1'b0;
            cnt    <= 4'h0;
          end
          RDATA: if (cnt == 4'h8) begin
            state  <= ACK_R;
            sda_oe <= 1'b0;
            ptr    <= ptr + 8'h01;
          end else begin
            sda_oe <= ~shift[6];
            shift  <= {shift[6:0], 1'b0};
            cnt    <= cnt + 4'h1;
          end
          ACK_R: if (!nack) begin
            state  <= RDATA;
            shift  <= rd_data;
            sda_oe <= ~rd_data[7];
            cnt    <= 4'h1;
          end else begin
            state <= IDLE;
          end
          default: state <= IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/backlight_properties.sv
/* assertions on the sequencer top ports.
   assumes CYCLES_PER_MS of 5, so the fastest fade step lasts 3 cycles. */
`timescale 1ns/1ps
`default_nettype none
module seq_checker #(
  parameter CYCLES_PER_MS = 5
) (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // standby pin
  input wire logic        STANDBY_PIN_N,
  // sink drive
  input wire logic [6:0]  SINK_CODE,
  input wire logic        SQUARE_LAW,
  input wire logic [14:0] SINK_CURRENT_UA,
  input wire logic        BACKLIGHT_ON
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ****
  // properties
  // ****
  // standby may cut at once, so steps are judged only while it is high
  one_step_a: assert property (STANDBY_PIN_N && $past(STANDBY_PIN_N, 3) |->
    7'(SINK_CODE - $past(SINK_CODE)) inside {7'h00, 7'h01, 7'h7F}) else $error("code jump");
  on_follows_a: assert property (
    BACKLIGHT_ON == ($past(SINK_CODE) != 7'h00)) else $error("on flag wrong");
  standby_cut_a: assert property (
    !STANDBY_PIN_N [*4] |-> SINK_CODE == 7'h00) else $error("standby not cut");
  zero_current_a: assert property (
    SINK_CODE == 7'h00 |=> SINK_CURRENT_UA == 15'h0000) else $error("zero current");
  full_scale_a: assert property (
    SINK_CODE == 7'h7F |=> SINK_CURRENT_UA == 15'h7530) else $error("full scale");
  linear_step_a: assert property (
    !SQUARE_LAW && SINK_CODE == 7'h02 ##1 !SQUARE_LAW |-> SINK_CURRENT_UA == 15'h01D8)
    else $error("linear current");
  square_low_a: assert property (
    SQUARE_LAW && SINK_CODE == 7'h02 ##1 SQUARE_LAW |-> SINK_CURRENT_UA == 15'h0007)
    else $error("square current");
  step_pace_a: assert property ($changed(SINK_CODE) && SINK_CODE != 7'h00 |=>
    ($stable(SINK_CODE) || !STANDBY_PIN_N) [*2]) else $error("step too fast");
endmodule
bind backlight_sequencer seq_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .STANDBY_PIN_N(STANDBY_PIN_N), .SINK_CODE(SINK_CODE),
  .SQUARE_LAW(SQUARE_LAW), .SINK_CURRENT_UA(SINK_CURRENT_UA), .BACKLIGHT_ON(BACKLIGHT_ON));
`default_nettype wire

// ===== verification/i2c_host_model.sv
/* i2c host model: one register write or pointer-then-read per call.
   assumes the bench resolves sda with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda,
  output var  logic scl,
  output var  logic pull
);
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  // sda moves mid-low: moving it with scl would read as start or stop
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    pull = !b;
    wt(3);
    scl = 1'b1;
    wt(5);
    r   = sda;
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                         output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
  task automatic xfer(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                      input logic rd, output logic [7:0] q, output logic nak);
    logic k1, k2, k3;
    pull = 1'b1;
    wt(5);
    scl = 1'b0;
    byte_io({dev, 1'b0}, 1'b1, q, k1);
    byte_io(a, 1'b1, q, k2);
    nak = k1 | k2;
    if (rd) begin
      wt(2);
      pull = 1'b0;
      wt(3);
      scl = 1'b1;
      wt(5);
      pull = 1'b1;
      wt(5);
      scl = 1'b0;
      byte_io({dev, 1'b1}, 1'b1, q, k3);
      byte_io(8'hFF, 1'b1, q, k1);
    end else begin
      byte_io(d, 1'b1, q, k3);
    end
    nak = nak | k3;
    wt(2);
    pull = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(5);
    pull = 1'b0;
    wt(5);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/* self-checking bench for the backlight sequencer.
   assumes the host model and the bound checker; one second is 5000 cycles. */
`timescale 1ns/1ps
`include "backlight_consts.vh"
`default_nettype none
module tb_top;
  localparam int CPM = 5;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            stby_n = 1'b1;
  wire logic       scl, pull, sda_out, sda_oe, on, sq;
  wire logic [6:0] code;
  wire logic [14:0] ua;
  wire logic       sda;
  int              fail_count = 0;
  int              total_checks = 0;
  int              n;
  logic [7:0]      q;
  logic            nak;
  assign sda = !((sda_oe && !sda_out) || pull);
  always #10 clk = !clk;
  backlight_sequencer #(.CYCLES_PER_MS(CPM)) i_dut (.REF_CLK(clk), .RST_N(rst_n), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .STANDBY_PIN_N(stby_n),
    .SINK_CODE(code), .SQUARE_LAW(sq), .SINK_CURRENT_UA(ua), .BACKLIGHT_ON(on));
  i2c_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  // ****
  // helpers
  // ****
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_time(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(`I2C_ADDR_RESET, a, d, 1'b0, q, nak);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.xfer(`I2C_ADDR_RESET, a, 8'h00, 1'b1, q, nak);
    check8(q, e);
  endtask
  // bounded waits; a hang shows as a wrong count
  task automatic until_is(input logic [6:0] v);
    n = 0;
    while (code !== v && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 30000) check8({1'b0, code}, {1'b0, v});
  endtask
  function automatic int step_cyc(input logic [3:0] r, input logic [1:0] law);
    int ms;
    case (r)
      4'h0: ms = 100;
      4'h9: ms = 2700;
      4'hA: ms = 3000;
      4'hB: ms = 3500;
      4'hC: ms = 4000;
      4'hD: ms = 4500;
      4'hE: ms = 5000;
      4'hF: ms = 5500;
      default: ms = 300 * r;
    endcase
    step_cyc = ms * CPM / 127;
    if (law == 2'h2) step_cyc = step_cyc * 15 / 8;
  endfunction
  initial begin
    repeat (120000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  // ****
  // tests
  // ****
  initial begin
    logic [7:0] d;
    logic [3:0] r;
    logic [1:0] law;
    void'($urandom(32'h27A13E15));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int a = 6; a < 10; a++) begin
      rd(8'(a), 8'h00);
      d = $urandom | 8'h80;
      wr(8'(a), d);
      rd(8'(a), (a == 8) ? d : {1'b0, d[6:0]});
    end
    rd(8'h30, 8'h00);
    i_host.xfer(7'h2B, 8'h06, 8'h55, 1'b0, q, nak);
    check8({7'h00, nak}, 8'h01);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h7F);
    wr(8'h01, 8'h01);
    until_is(7'h7F);
    check_time(n, 127 * step_cyc(0, 0), 30);
    wr(8'h01, 8'h00);
    until_is(7'h00);
    check_time(n, 127 * step_cyc(0, 0), 30);
    wr(8'h09, 8'h0C);
    for (int i = 0; i < 16; i++) begin
      r   = 4'(i);
      law = 2'(i);
      wr(8'h04, {5'h00, law, 1'b0});
      wr(8'h08, {~r, r});
      wr(8'h01, 8'h01);
      until_is(7'h08);
      until_is(7'h0C);
      check_time(n, 4 * step_cyc(r, law), 5 + step_cyc(r, law) / 4);
      wr(8'h01, 8'h00);
      // a fast fade-out passes the upper codes before the write returns
      until_is(7'h04);
      until_is(7'h00);
      check_time(n, 4 * step_cyc(~r, law), 5 + step_cyc(~r, law) / 4);
    end
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h08);
    wr(8'h0A, 8'h02);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h01);
    wr(8'h01, 8'h01);
    until_is(7'h08);
    repeat (2000) @(negedge clk);
    wr(8'h07, 8'h01);
    until_is(7'h07);
    check_time(n, 5000, 40);
    until_is(7'h02);
    check_time(n, 15, 4);
    until_is(7'h01);
    check_time(n, 4985, 40);
    wr(8'h01, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h01);
    until_is(7'h08);
    wr(8'h01, 8'h11);
    until_is(7'h02);
    check8({1'b0, code}, 8'h02);
    wr(8'h01, 8'h01);
    until_is(7'h08);
    check8({1'b0, code}, 8'h08);
    stby_n = 1'b0;
    repeat (5) @(negedge clk);
    check8({1'b0, code}, 8'h00);
    stby_n = 1'b1;
    until_is(7'h08);
    check8({1'b0, code}, 8'h08);
    complete_run;
  end
endmodule
`default_nettype wire
